// ===== include/uv_supervisor_pkg.sv
package uv_supervisor_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 16;

    // Register index inside a channel page, channel on address bit 4
    localparam int          CH_BIT        = 4;
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_VCMD      = 4'h1;
    localparam logic [3:0]  REG_UVF_LIM   = 4'h2;
    localparam logic [3:0]  REG_UVW_LIM   = 4'h3;
    localparam logic [3:0]  REG_VMIN      = 4'h4;
    localparam logic [3:0]  REG_VMAX      = 4'h5;
    localparam logic [3:0]  REG_MARGIN_HI = 4'h6;
    localparam logic [3:0]  REG_MARGIN_LO = 4'h7;
    localparam logic [3:0]  REG_TRIM      = 4'h8;
    localparam logic [3:0]  REG_DROOP     = 4'h9;
    localparam logic [3:0]  REG_TON_LIM   = 4'hA;
    localparam logic [3:0]  REG_OCF_LIM   = 4'hB;
    localparam logic [3:0]  REG_STATUS    = 4'hC;
    localparam logic [3:0]  REG_MASK      = 4'hD;
    localparam logic [3:0]  REG_TARGET    = 4'hE;
    localparam logic [3:0]  REG_SCALE     = 4'hF;

    // Control fields
    localparam int          CTRL_EN       = 0;
    localparam int          CTRL_UVF_ACT  = 1;
    localparam int          CTRL_TON_ACT  = 2;
    localparam int          CTRL_MSEL_LO  = 3;
    localparam int          CTRL_MSEL_HI  = 4;
    localparam logic [1:0]  MSEL_HIGH     = 2'h1;
    localparam logic [1:0]  MSEL_LOW      = 2'h2;

    // Status fields
    localparam int          ST_UVF        = 0;
    localparam int          ST_UVW        = 1;
    localparam int          ST_TON        = 2;
    localparam int          ST_MINMAX     = 3;
    localparam int          ST_W          = 4;

    // Values after reset, millivolts unless noted
    localparam logic [15:0] RST_CTRL      = 16'h0006;
    localparam logic [15:0] RST_VCMD      = 16'h03E8;
    localparam logic [15:0] RST_UVF_OFS   = 16'h0100;
    localparam logic [15:0] RST_UVW_OFS   = 16'h0080;
    localparam logic [15:0] RST_VMIN      = 16'h00FA;
    localparam logic [15:0] RST_VMAX      = 16'h157C;
    localparam logic [15:0] RST_MARGIN_HI = 16'h041A;
    localparam logic [15:0] RST_MARGIN_LO = 16'h03B6;
    localparam logic [15:0] RST_TRIM      = 16'h0000;
    localparam logic [15:0] RST_DROOP     = 16'h0000;
    localparam logic [15:0] RST_TON_LIM   = 16'h000A;
    localparam logic [15:0] RST_OCF_LIM   = 16'h0064;
    localparam logic [15:0] RST_MASK      = 16'h0000;
    localparam logic [1:0]  RST_SCALE     = 2'h0;

    // Offset quantisation
    localparam logic [15:0] UVF_STEP_MV   = 16'h0020;
    localparam logic [15:0] UVF_MIN_MV    = 16'h0020;
    localparam logic [15:0] UVF_MAX_MV    = 16'h01C0;
    localparam logic [15:0] UVW_STEP_MV   = 16'h0008;
    localparam logic [15:0] UVW_MIN_MV    = 16'h0018;
    localparam logic [15:0] UVW_MAX_MV    = 16'h01C0;

    // Droop in 1/16 milliohm, product shifted down to millivolts
    localparam int          DROOP_SHIFT   = 4;

    // Timing
    localparam int          CLK_HZ        = 20_000_000;
    localparam int          TON_TICK_US   = 1000;
    localparam int          TON_TICK_CYC  = CLK_HZ / 1_000_000 * TON_TICK_US;
    localparam int          RAMP_TICK_US  = 1;
    localparam int          RAMP_TICK_CYC = CLK_HZ / 1_000_000 * RAMP_TICK_US;
    localparam logic [15:0] RAMP_STEP_MV  = 16'h0001;

    typedef struct packed {
        logic [15:0] sense_plus_pin;
        logic [15:0] sense_minus_pin;
        logic [9:0]  iout;
    } telemetry_t;

    typedef enum logic [3:0] {
        CONV_OFF   = 4'b0001,
        CONV_RISE  = 4'b0010,
        CONV_REG   = 4'b0100,
        CONV_FAULT = 4'b1000
    } conv_t;

endpackage : uv_supervisor_pkg

// ===== logic/output_voltage_fault_supervisor.sv
`timescale 1ns/1ps
module output_voltage_fault_supervisor
    import uv_supervisor_pkg::*;
#(
    parameter int TON_TICK_CYCLES = TON_TICK_CYC
)
(
    input  wire logic                   CLOCK,
    input  wire logic                   RST_N,
    input  wire logic [ADDR_W-1:0]      ADDR,
    input  wire logic [DATA_W-1:0]      WDATA,
    input  wire logic                   WR_EN,
    input  wire logic                   RD_EN,
    output logic      [DATA_W-1:0]      RDATA,
    input  wire telemetry_t [1:0]       TELEMETRY,
    input  wire logic [1:0]             TELEMETRY_VALID,
    input  wire logic [1:0]             FIRST_PULSE,
    output logic      [1:0]             PHASE_TRISTATE,
    output logic      [1:0]             REGULATOR_READY_OUT,
    output logic      [1:0][15:0]       VOUT_TARGET,
    output logic                        SMBALERT_N
);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic c,
                                 input logic [3:0] r);
        hit = (a[ADDR_W-1:CH_BIT+1] == '0) && (a[CH_BIT] == c) && (a[3:0] == r);
    endfunction : hit

    function automatic logic [15:0] quant(input logic [15:0] cmd, input logic [15:0] lim,
                                          input logic [1:0] sc, input logic [15:0] step,
                                          input logic [15:0] mn, input logic [15:0] mx);
        logic signed [16:0] d;
        logic signed [16:0] q;
        d = $signed({1'b0, cmd}) - $signed({1'b0, lim});
        q = d >>> sc;
        q = q & ~$signed({1'b0, step - 16'h0001});
        if (q < $signed({1'b0, mn}))
        begin
            q = $signed({1'b0, mn});
        end
        else if (q > $signed({1'b0, mx}))
        begin
            q = $signed({1'b0, mx});
        end
        quant = q[15:0];
    endfunction : quant

    function automatic logic signed [18:0] thresh(input logic [15:0] cmd,
                                                  input logic [15:0] ofs,
                                                  input logic [15:0] droop,
                                                  input logic [15:0] amps);
        logic [31:0] drop;
        drop = (droop * amps) >> DROOP_SHIFT;
        thresh = $signed({3'b000, cmd}) - $signed({3'b000, ofs})
               - $signed({1'b0, drop[17:0]});
    endfunction : thresh

    logic [15:0]        ctrl_reg      [2];
    logic [15:0]        vcmd_reg      [2];
    logic [15:0]        uvf_ofs_reg   [2];
    logic [15:0]        uvw_ofs_reg   [2];
    logic [15:0]        vmin_reg      [2];
    logic [15:0]        vmax_reg      [2];
    logic [15:0]        mhi_reg       [2];
    logic [15:0]        mlo_reg       [2];
    logic [15:0]        trim_reg      [2];
    logic [15:0]        droop_reg     [2];
    logic [15:0]        ton_lim_reg   [2];
    logic [15:0]        ocf_lim_reg   [2];
    logic [ST_W-1:0]    status_reg    [2];
    logic [ST_W-1:0]    mask_reg      [2];
    logic [1:0]         scale_reg     [2];
    logic [15:0]        target_reg    [2];
    logic [15:0]        ton_cnt_reg   [2];
    conv_t              state_reg     [2];
    conv_t              state_next    [2];
    logic [1:0]         uvf_evt;
    logic [1:0]         uvw_evt;
    logic [1:0]         ton_evt;
    logic [1:0]         reached;
    logic [1:0]         minmax_evt;
    logic [15:0]        clamped       [2];
    logic [31:0]        ms_cnt_reg;
    logic [31:0]        ramp_cnt_reg;
    logic               ms_tick;
    logic               ramp_tick;
    logic [15:0]        rd_next;

    // Tick dividers
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ms_cnt_reg   <= '0;
            ramp_cnt_reg <= '0;
        end
        else
        begin
            ms_cnt_reg   <= ms_tick ? '0 : ms_cnt_reg + 32'h00000001;
            ramp_cnt_reg <= ramp_tick ? '0 : ramp_cnt_reg + 32'h00000001;
        end
    end

    assign ms_tick   = (ms_cnt_reg == 32'(TON_TICK_CYCLES - 1));
    assign ramp_tick = (ramp_cnt_reg == 32'(RAMP_TICK_CYC - 1));

    // Per-channel detection and state
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            logic signed [18:0] vdiff;
            logic signed [18:0] req;
            logic [15:0]        base;
            logic               armed;
            base  = '0;
            req   = '0;
            vdiff = $signed({3'b000, TELEMETRY[c].sense_plus_pin})
                  - $signed({3'b000, TELEMETRY[c].sense_minus_pin});
            armed = (state_reg[c] == CONV_RISE) || (state_reg[c] == CONV_REG);
            uvf_evt[c] = TELEMETRY_VALID[c] && armed && ctrl_reg[c][CTRL_EN]
                       && (vdiff < thresh(vcmd_reg[c], uvf_ofs_reg[c], droop_reg[c],
                                          {6'h00, TELEMETRY[c].iout}));
            uvw_evt[c] = TELEMETRY_VALID[c] && (state_reg[c] == CONV_REG)
                       && (vdiff < thresh(vcmd_reg[c], uvw_ofs_reg[c], droop_reg[c],
                                          {6'h00, TELEMETRY[c].iout}));
            reached[c] = TELEMETRY_VALID[c]
                       && (vdiff > thresh(vcmd_reg[c], uvf_ofs_reg[c], droop_reg[c],
                                          ocf_lim_reg[c]));
            ton_evt[c] = (state_reg[c] == CONV_RISE) && ms_tick
                       && (ton_cnt_reg[c] == ton_lim_reg[c]);
            case (ctrl_reg[c][CTRL_MSEL_HI:CTRL_MSEL_LO])
                MSEL_HIGH: base = mhi_reg[c];
                MSEL_LOW:  base = mlo_reg[c];
                default:   base = vcmd_reg[c];
            endcase
            req = $signed({3'b000, base}) + $signed({{3{trim_reg[c][15]}}, trim_reg[c]});
            minmax_evt[c] = (req < $signed({3'b000, vmin_reg[c]}))
                          || (req > $signed({3'b000, vmax_reg[c]}));
            if (req < $signed({3'b000, vmin_reg[c]}))
            begin
                clamped[c] = vmin_reg[c];
            end
            else if (req > $signed({3'b000, vmax_reg[c]}))
            begin
                clamped[c] = vmax_reg[c];
            end
            else
            begin
                clamped[c] = req[15:0];
            end
            state_next[c] = state_reg[c];
            case (state_reg[c])
                CONV_OFF:
                begin
                    if (ctrl_reg[c][CTRL_EN] && FIRST_PULSE[c])
                    begin
                        state_next[c] = CONV_RISE;
                    end
                end
                CONV_RISE:
                begin
                    if (!ctrl_reg[c][CTRL_EN])
                    begin
                        state_next[c] = CONV_OFF;
                    end
                    else if (uvf_evt[c] && ctrl_reg[c][CTRL_UVF_ACT])
                    begin
                        state_next[c] = CONV_FAULT;
                    end
                    else if (ton_evt[c] && ctrl_reg[c][CTRL_TON_ACT])
                    begin
                        state_next[c] = CONV_FAULT;
                    end
                    else if (reached[c])
                    begin
                        state_next[c] = CONV_REG;
                    end
                end
                CONV_REG:
                begin
                    if (!ctrl_reg[c][CTRL_EN])
                    begin
                        state_next[c] = CONV_OFF;
                    end
                    else if (uvf_evt[c] && ctrl_reg[c][CTRL_UVF_ACT])
                    begin
                        state_next[c] = CONV_FAULT;
                    end
                end
                CONV_FAULT:
                begin
                    if (!ctrl_reg[c][CTRL_EN])
                    begin
                        state_next[c] = CONV_OFF;
                    end
                end
                default: state_next[c] = CONV_OFF;
            endcase
        end
    end

    // State, turn-on timer and target ramp
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int c = 0; c < 2; c++)
            begin
                state_reg[c]   <= CONV_OFF;
                ton_cnt_reg[c] <= '0;
                target_reg[c]  <= RST_VCMD;
            end
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                state_reg[c] <= state_next[c];
                if (state_reg[c] != CONV_RISE)
                begin
                    ton_cnt_reg[c] <= '0;
                end
                else if (ms_tick && ton_cnt_reg[c] != 16'hFFFF)
                begin
                    ton_cnt_reg[c] <= ton_cnt_reg[c] + 16'h0001;
                end
                if (ramp_tick)
                begin
                    if (target_reg[c] + RAMP_STEP_MV <= clamped[c])
                    begin
                        target_reg[c] <= target_reg[c] + RAMP_STEP_MV;
                    end
                    else if (target_reg[c] >= clamped[c] + RAMP_STEP_MV)
                    begin
                        target_reg[c] <= target_reg[c] - RAMP_STEP_MV;
                    end
                    else
                    begin
                        target_reg[c] <= clamped[c];
                    end
                end
            end
        end
    end

    // Software registers
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int c = 0; c < 2; c++)
            begin
                ctrl_reg[c]    <= RST_CTRL;
                vcmd_reg[c]    <= RST_VCMD;
                uvf_ofs_reg[c] <= RST_UVF_OFS;
                uvw_ofs_reg[c] <= RST_UVW_OFS;
                vmin_reg[c]    <= RST_VMIN;
                vmax_reg[c]    <= RST_VMAX;
                mhi_reg[c]     <= RST_MARGIN_HI;
                mlo_reg[c]     <= RST_MARGIN_LO;
                trim_reg[c]    <= RST_TRIM;
                droop_reg[c]   <= RST_DROOP;
                ton_lim_reg[c] <= RST_TON_LIM;
                ocf_lim_reg[c] <= RST_OCF_LIM;
                mask_reg[c]    <= RST_MASK[ST_W-1:0];
                scale_reg[c]   <= RST_SCALE;
            end
        end
        else if (WR_EN)
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (hit(ADDR, c[0], REG_CTRL))      ctrl_reg[c]    <= WDATA;
                if (hit(ADDR, c[0], REG_VCMD))      vcmd_reg[c]    <= WDATA;
                if (hit(ADDR, c[0], REG_UVF_LIM))
                begin
                    uvf_ofs_reg[c] <= quant(vcmd_reg[c], WDATA, scale_reg[c], UVF_STEP_MV,
                                            UVF_MIN_MV, UVF_MAX_MV);
                end
                if (hit(ADDR, c[0], REG_UVW_LIM))
                begin
                    uvw_ofs_reg[c] <= quant(vcmd_reg[c], WDATA, scale_reg[c], UVW_STEP_MV,
                                            UVW_MIN_MV, UVW_MAX_MV);
                end
                if (hit(ADDR, c[0], REG_VMIN))      vmin_reg[c]    <= WDATA;
                if (hit(ADDR, c[0], REG_VMAX))      vmax_reg[c]    <= WDATA;
                if (hit(ADDR, c[0], REG_MARGIN_HI)) mhi_reg[c]     <= WDATA;
                if (hit(ADDR, c[0], REG_MARGIN_LO)) mlo_reg[c]     <= WDATA;
                if (hit(ADDR, c[0], REG_TRIM))      trim_reg[c]    <= WDATA;
                if (hit(ADDR, c[0], REG_DROOP))     droop_reg[c]   <= WDATA;
                if (hit(ADDR, c[0], REG_TON_LIM))   ton_lim_reg[c] <= WDATA;
                if (hit(ADDR, c[0], REG_OCF_LIM))   ocf_lim_reg[c] <= WDATA;
                if (hit(ADDR, c[0], REG_MASK))      mask_reg[c]    <= WDATA[ST_W-1:0];
                if (hit(ADDR, c[0], REG_SCALE))     scale_reg[c]   <= WDATA[1:0];
            end
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int c = 0; c < 2; c++)
            begin
                status_reg[c] <= '0;
            end
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                logic [ST_W-1:0] clr;
                logic [ST_W-1:0] set;
                clr = (WR_EN && hit(ADDR, c[0], REG_STATUS)) ? WDATA[ST_W-1:0] : '0;
                set = '0;
                set[ST_UVF]    = uvf_evt[c];
                set[ST_UVW]    = uvw_evt[c];
                set[ST_TON]    = ton_evt[c];
                set[ST_MINMAX] = minmax_evt[c];
                status_reg[c] <= (status_reg[c] & ~clr) | set;
            end
        end
    end

    // Read data, one cycle after the strobe
    always_comb
    begin
        logic c;
        c = ADDR[CH_BIT];
        rd_next = '0;
        if (ADDR[ADDR_W-1:CH_BIT+1] == '0)
        begin
            case (ADDR[3:0])
                REG_CTRL:      rd_next = ctrl_reg[c];
                REG_VCMD:      rd_next = vcmd_reg[c];
                REG_UVF_LIM:   rd_next = vcmd_reg[c] - uvf_ofs_reg[c];
                REG_UVW_LIM:   rd_next = vcmd_reg[c] - uvw_ofs_reg[c];
                REG_VMIN:      rd_next = vmin_reg[c];
                REG_VMAX:      rd_next = vmax_reg[c];
                REG_MARGIN_HI: rd_next = mhi_reg[c];
                REG_MARGIN_LO: rd_next = mlo_reg[c];
                REG_TRIM:      rd_next = trim_reg[c];
                REG_DROOP:     rd_next = droop_reg[c];
                REG_TON_LIM:   rd_next = ton_lim_reg[c];
                REG_OCF_LIM:   rd_next = ocf_lim_reg[c];
                REG_STATUS:    rd_next = {{(16-ST_W){1'b0}}, status_reg[c]};
                REG_MASK:      rd_next = {{(16-ST_W){1'b0}}, mask_reg[c]};
                REG_TARGET:    rd_next = target_reg[c];
                REG_SCALE:     rd_next = {14'h0000, scale_reg[c]};
                default:       rd_next = '0;
            endcase
        end
    end

    // Outputs
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RDATA               <= '0;
            PHASE_TRISTATE      <= '0;
            REGULATOR_READY_OUT <= '0;
            VOUT_TARGET         <= {RST_VCMD, RST_VCMD};
            SMBALERT_N          <= 1'b1;
        end
        else
        begin
            RDATA <= RD_EN ? rd_next : '0;
            for (int c = 0; c < 2; c++)
            begin
                PHASE_TRISTATE[c]      <= (state_next[c] == CONV_FAULT);
                REGULATOR_READY_OUT[c] <= (state_next[c] == CONV_REG);
                VOUT_TARGET[c]         <= target_reg[c];
            end
            SMBALERT_N <= ~(|(status_reg[0] & ~mask_reg[0])
                          | |(status_reg[1] & ~mask_reg[1]));
        end
    end

endmodule : output_voltage_fault_supervisor

// ===== tb/output_voltage_fault_supervisor_props.sv
`timescale 1ns/1ps
module output_voltage_fault_supervisor_props
    import uv_supervisor_pkg::*;
(
    input wire logic             CLOCK,
    input wire logic             RST_N,
    input wire logic             WR_EN,
    input wire logic [1:0]       TELEMETRY_VALID,
    input wire logic [1:0]       PHASE_TRISTATE,
    input wire logic [1:0]       REGULATOR_READY_OUT,
    input wire logic [1:0][15:0] VOUT_TARGET
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    AST_READY0: assert property (PHASE_TRISTATE[0] |-> !REGULATOR_READY_OUT[0])
        else $error("ready high with channel 0 tristated");
    AST_READY1: assert property (PHASE_TRISTATE[1] |-> !REGULATOR_READY_OUT[1])
        else $error("ready high with channel 1 tristated");
    AST_REG0: assert property ($rose(REGULATOR_READY_OUT[0]) |-> $past(TELEMETRY_VALID[0]))
        else $error("channel 0 regulating without sample");
    AST_REG1: assert property ($rose(REGULATOR_READY_OUT[1]) |-> $past(TELEMETRY_VALID[1]))
        else $error("channel 1 regulating without sample");
    AST_HOLD0: assert property (PHASE_TRISTATE[0] && !WR_EN && !$past(WR_EN) |=> PHASE_TRISTATE[0])
        else $error("channel 0 left fault without write");
    AST_STEP0: assert property ($changed(VOUT_TARGET[0]) |->
        (VOUT_TARGET[0] - $past(VOUT_TARGET[0]) == 16'h0001)
        || ($past(VOUT_TARGET[0]) - VOUT_TARGET[0] == 16'h0001)) else $error("target 0 jump");
    AST_STEP1: assert property ($changed(VOUT_TARGET[1]) |->
        (VOUT_TARGET[1] - $past(VOUT_TARGET[1]) == 16'h0001)
        || ($past(VOUT_TARGET[1]) - VOUT_TARGET[1] == 16'h0001)) else $error("target 1 jump");
    AST_RATE1: assert property ($changed(VOUT_TARGET[1]) |=> $stable(VOUT_TARGET[1])[*8])
        else $error("target 1 ramps too fast");
endmodule : output_voltage_fault_supervisor_props
bind output_voltage_fault_supervisor output_voltage_fault_supervisor_props props_inst (
    .CLOCK(CLOCK), .RST_N(RST_N), .WR_EN(WR_EN), .TELEMETRY_VALID(TELEMETRY_VALID),
    .PHASE_TRISTATE(PHASE_TRISTATE), .REGULATOR_READY_OUT(REGULATOR_READY_OUT),
    .VOUT_TARGET(VOUT_TARGET));

// ===== tb/pmbus_host_model.sv
`timescale 1ns/1ps
module pmbus_host_model
    import uv_supervisor_pkg::*;
(
    input  wire logic              clock,
    output logic      [ADDR_W-1:0] addr = 8'h00,
    output logic      [DATA_W-1:0] wdata = 16'h0000,
    output logic                   wr_en = 1'b0,
    output logic                   rd_en = 1'b0
);
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        wdata <= ~d;
        addr <= ~a;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        addr <= ~a;
    endtask : rd
endmodule : pmbus_host_model

// ===== tb/output_voltage_fault_supervisor_test.sv
`timescale 1ns/1ps
module output_voltage_fault_supervisor_test;
    import uv_supervisor_pkg::*;
    logic             CLOCK = 1'b0;
    logic             RST_N = 1'b0;
    logic [7:0]       addr;
    logic [15:0]      wdata;
    logic             wr_en;
    logic             rd_en;
    logic [15:0]      rdata;
    telemetry_t [1:0] tel = '0;
    logic [1:0]       tel_v = 2'h0;
    logic [1:0]       pulse = 2'h0;
    logic [1:0]       tri_s;
    logic [1:0]       rdy;
    logic [1:0][15:0] tgt;
    logic             alert_n;
    logic [15:0]      exp_q[$];
    logic             rd_q = 1'b0;
    int               num_errors = 0;
    int               tests_run = 0;
    int               seed = 32'h4401CD9D;
    logic [3:0]       regs[5] = '{REG_CTRL, REG_UVF_LIM, REG_UVW_LIM, REG_VMAX, REG_OCF_LIM};
    logic [15:0]      rv[5] = '{RST_CTRL, RST_VCMD - RST_UVF_OFS, RST_VCMD - RST_UVW_OFS,
                                RST_VMAX, RST_OCF_LIM};
    always #25 CLOCK = ~CLOCK;
    pmbus_host_model host_inst (.clock(CLOCK), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en));
    output_voltage_fault_supervisor #(.TON_TICK_CYCLES(20)) output_voltage_fault_supervisor_inst (
        .CLOCK(CLOCK), .RST_N(RST_N), .ADDR(addr), .WDATA(wdata), .WR_EN(wr_en),
        .RD_EN(rd_en), .RDATA(rdata), .TELEMETRY(tel), .TELEMETRY_VALID(tel_v),
        .FIRST_PULSE(pulse), .PHASE_TRISTATE(tri_s), .REGULATOR_READY_OUT(rdy),
        .VOUT_TARGET(tgt), .SMBALERT_N(alert_n));
    function logic [7:0] a(input logic c, input logic [3:0] r);
        return {3'h0, c, r};
    endfunction : a
    task end_sim;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    task chk(input logic [15:0] got, input logic [15:0] e);
        tests_run++;
        if (got !== e)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, e);
        end
    endtask : chk
    task rd(input logic [7:0] ad, input logic [15:0] e);
        exp_q.push_back(e);
        host_inst.rd(ad);
    endtask : rd
    task tx(input int c, input logic [15:0] v, input logic [9:0] i);
        @(posedge CLOCK);
        tel[c].sense_plus_pin <= v + 16'h0032;
        tel[c].sense_minus_pin <= 16'h0032;
        tel[c].iout <= i;
        tel_v[c] <= 1'b1;
        @(posedge CLOCK);
        tel_v[c] <= 1'b0;
        repeat (3) @(posedge CLOCK);
    endtask : tx
    always @(posedge CLOCK)
    begin
        rd_q <= rd_en;
        if (rd_q)
            chk(rdata, exp_q.pop_front());
    end
    initial
    begin
        repeat (60000) @(posedge CLOCK);
        num_errors++;
        end_sim();
    end
    initial
    begin
        repeat (16) @(posedge CLOCK);
        RST_N <= 1'b1;
        for (int k = 0; k < 5; k++)
            rd(a(1'b0, regs[k]), rv[k]);
        rd(8'h20, 16'h0000);
        host_inst.wr(a(1'b0, REG_UVF_LIM), 16'h02BC);
        host_inst.wr(a(1'b0, REG_UVW_LIM), 16'h0384);
        rd(a(1'b0, REG_UVF_LIM), 16'h02C8);
        rd(a(1'b0, REG_UVW_LIM), 16'h0388);
        host_inst.wr(a(1'b0, REG_VCMD), 16'h044C);
        rd(a(1'b0, REG_UVF_LIM), 16'h032C);
        rd(a(1'b0, REG_UVW_LIM), 16'h03EC);
        host_inst.wr(a(1'b0, REG_DROOP), 16'h0010);
        host_inst.wr(a(1'b0, REG_CTRL), 16'h0007);
        pulse[0] <= 1'b1;
        tx(0, 16'h044C + 16'($random(seed) & 255), 10'($random(seed) & 63));
        chk({15'h0, rdy[0]}, 16'h0001);
        tx(0, 16'h03B6, 10'd100);
        rd(a(1'b0, REG_STATUS), 16'h0000);
        tx(0, 16'h0352, 10'd100);
        chk({15'h0, rdy[0]}, 16'h0001);
        chk({15'h0, alert_n}, 16'h0000);
        rd(a(1'b0, REG_STATUS), 16'h0002);
        tx(0, 16'h02BC, 10'd100);
        chk({14'h0, tri_s, rdy}, 16'h0001 << 2);
        rd(a(1'b0, REG_STATUS), 16'h0003);
        host_inst.wr(a(1'b0, REG_STATUS), 16'h000F);
        rd(a(1'b0, REG_STATUS), 16'h0000);
        chk({15'h0, alert_n}, 16'h0001);
        host_inst.wr(a(1'b0, REG_CTRL), 16'h0006);
        tx(0, 16'h0064, 10'd0);
        chk({14'h0, tri_s}, 16'h0000);
        rd(a(1'b0, REG_STATUS), 16'h0000);
        host_inst.wr(a(1'b1, REG_UVF_LIM), 16'h03DE);
        host_inst.wr(a(1'b1, REG_UVW_LIM), 16'h03DE);
        rd(a(1'b1, REG_UVF_LIM), 16'h03C8);
        rd(a(1'b1, REG_UVW_LIM), 16'h03D0);
        host_inst.wr(a(1'b1, REG_MASK), 16'h000F);
        host_inst.wr(a(1'b1, REG_TON_LIM), 16'h0002);
        host_inst.wr(a(1'b1, REG_CTRL), 16'h0007);
        pulse[1] <= 1'b1;
        for (int n = 0; n < 200 && tri_s[1] !== 1'b1; n++)
            @(posedge CLOCK);
        chk({14'h0, tri_s}, 16'h0002);
        chk({15'h0, alert_n}, 16'h0001);
        host_inst.wr(a(1'b1, REG_VMIN), 16'h03DE);
        host_inst.wr(a(1'b1, REG_VCMD), 16'h0384);
        repeat (400) @(posedge CLOCK);
        chk(tgt[1], 16'h03DE);
        rd(a(1'b1, REG_STATUS), 16'h000C);
        host_inst.wr(a(1'b1, REG_VMAX), 16'h0410);
        host_inst.wr(a(1'b1, REG_CTRL), 16'h000F);
        repeat (1100) @(posedge CLOCK);
        rd(a(1'b1, REG_TARGET), 16'h0410);
        host_inst.wr(a(1'b1, REG_TRIM), 16'h0032);
        host_inst.wr(a(1'b1, REG_CTRL), 16'h0017);
        repeat (900) @(posedge CLOCK);
        rd(a(1'b1, REG_TARGET), 16'h03E8);
        host_inst.wr(a(1'b1, REG_SCALE), 16'h0001);
        host_inst.wr(a(1'b1, REG_UVF_LIM), 16'h0244);
        rd(a(1'b1, REG_UVF_LIM), 16'h02E4);
        host_inst.wr(a(1'b0, REG_CTRL), 16'h0005);
        tx(0, 16'h02BC, 10'd100);
        chk({14'h0, tri_s}, 16'h0002);
        rd(a(1'b0, REG_STATUS), 16'h0001);
        repeat (4) @(posedge CLOCK);
        end_sim();
    end
endmodule : output_voltage_fault_supervisor_test
